// ==== testbench/cil_ext_equip.sv ====
// External equipment model: drives input lines, sees driven output lines
module cil_ext_equip
    import cil_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [NUM_LINES-1:0] i_drive,
    input wire logic [NUM_LINES-1:0] i_pin,
    input wire logic [NUM_LINES-1:0] i_pin_oe,
    output logic [NUM_LINES-1:0] o_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // An open output shows the inverse, so a stale driven level cannot pass for real
    assign o_wire = (DIR_OUTPUT_RST & ((i_pin_oe & i_pin) | (~i_pin_oe & ~i_pin)))
        | (~DIR_OUTPUT_RST & i_drive);
endmodule

// ==== testbench/cil_line_ctrl_monitor.sv ====
// Checker: bus handshake and line direction relations at the block's ports
module cil_line_ctrl_monitor
    import cil_pkg::*;
#(
    parameter int N_LINES = NUM_LINES,
    parameter logic [N_LINES-1:0] DIR_OUTPUT = DIR_OUTPUT_RST
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [N_LINES-1:0] o_line_pin,
    input wire logic [N_LINES-1:0] o_line_pin_oe,
    input wire logic [N_LINES-1:0] o_line_input_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    logic req;
    assign req = i_avs_read | i_avs_write;
    wait_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_cause_a: assert property (!o_avs_waitrequest |-> $past(req))
        else $error("answer without a request");
    answer_bound_a: assert property (req |-> ##[0:3] !o_avs_waitrequest)
        else $error("request not answered in time");
    rdata_hold_a: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
        else $error("read data moved without a read");
    oe_dir_a: assert property ((o_line_pin_oe & ~DIR_OUTPUT) == '0)
        else $error("input line driven");
    pin_dir_a: assert property ((o_line_pin & ~DIR_OUTPUT) == '0)
        else $error("input line pin level set");
    lvl_dir_a: assert property ((o_line_input_level & DIR_OUTPUT) == '0)
        else $error("input level on output line");
    oe_cause_a: assert property ($changed(o_line_pin_oe) |-> $past(i_avs_write, 2))
        else $error("drive enable changed without a write");
    cover property (i_avs_read && !o_avs_waitrequest);
    cover property ($rose(o_line_pin[3]));
    cover property ($rose(o_line_input_level[0]));
endmodule

bind cil_line_ctrl cil_line_ctrl_monitor #(.N_LINES(N_LINES), .DIR_OUTPUT(DIR_OUTPUT)) i_mon (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_line_pin(o_line_pin),
    .o_line_pin_oe(o_line_pin_oe), .o_line_input_level(o_line_input_level));

// ==== testbench/cil_line_ctrl_test.sv ====
// Testbench: register table rows, debounce, inversion and event pulses
module cil_line_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cil_pkg::*;
    typedef struct {
        logic [2:0] sel;
        logic [5:0] ctrl;
        logic [1:0] stat;
        logic oe;
        logic pin;
    } cil_row_t;
    cil_row_t rows [8] = '{'{1, 6'h00, 2'h2, 0, 0}, '{1, 6'h10, 2'h2, 1, 0},
        '{1, 6'h12, 2'h3, 1, 1}, '{1, 6'h13, 2'h3, 1, 0}, '{1, 6'h11, 2'h2, 1, 1},
        '{3, 6'h12, 2'h3, 1, 1}, '{5, 6'h10, 2'h2, 1, 0}, '{0, 6'h12, 2'h0, 0, 0}};
    logic clk = 0, rst = 1, rd = 0, we = 0, wreq, frame_act = 0, row_act = 0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, q;
    logic [5:0] drv = '0, pin_in, pin, oe, lvl;
    int fails = 0, compares = 0;
    int s;
    cil_line_ctrl i_cil_line_ctrl (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_frame_active(frame_act),
        .i_row_active(row_act), .i_line_pin(pin_in), .o_line_pin(pin), .o_line_pin_oe(oe),
        .o_line_input_level(lvl));
    cil_ext_equip i_cil_ext_equip (.i_sys_clk(clk), .i_drive(drv), .i_pin(pin),
        .i_pin_oe(oe), .o_wire(pin_in));
    initial begin
        forever #5 clk = ~clk;
    end
    task stop_test;
        $display("Compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task bus(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        we <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 0;
        we <= 0;
        if (wreq !== 1'b0) begin
            fails++;
            stop_test();
        end
    endtask
    // Event pulse on line ln; the source is dropped mid-window so a second pulse would show
    task ev(int ln, bit row);
        int n;
        n = 0;
        if (row) row_act <= 1;
        else frame_act <= 1;
        for (int c = 0; c < 20; c++) begin
            @(posedge clk);
            if (c == 8) begin
                row_act <= 0;
                frame_act <= 0;
            end
            #1 n += (pin[ln] === 1'b1);
        end
        chk("pulse_cycles", 32'(n), 32'h4);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        foreach (rows[i]) begin
            bus(1, REG_SELECT, 32'(rows[i].sel));
            bus(1, REG_LINE_CTRL, 32'(rows[i].ctrl));
            repeat (2) @(posedge clk);
            s = rows[i].sel;
            #1 chk("line_oe", 32'(oe[s]), 32'(rows[i].oe));
            chk("line_pin", 32'(pin[s] & oe[s]), 32'(rows[i].pin));
            bus(0, REG_STATUS, 0);
            chk("status", q, {30'h0, rows[i].stat});
        end
        bus(0, REG_SETTLE, 0);
        chk("settle_rst", q, {16'h0, SETTLE_RST});
        bus(0, REG_PULSE_LEN, 0);
        chk("pulse_rst", q, {24'h0, PULSE_LEN_RST});
        bus(0, 8'h20, 0);
        chk("unmapped", q, 32'h0);
        bus(1, REG_SELECT, 32'h6);
        bus(0, REG_STATUS, 0);
        chk("sel_six", q, 32'h0);
        bus(1, REG_SETTLE, 32'h5);
        bus(1, REG_SELECT, 32'h0);
        bus(1, REG_LINE_CTRL, 32'h0);
        drv[0] <= 1;
        repeat (3) @(posedge clk);
        drv[0] <= 0;
        @(posedge clk);
        drv[0] <= 1;
        repeat (3) @(posedge clk);
        #1 chk("glitch", 32'(lvl[0]), 32'h0);
        repeat (8) @(posedge clk);
        #1 chk("settled", 32'(lvl[0]), 32'h1);
        bus(1, REG_LINE_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        #1 chk("inv_in", 32'(lvl[0]), 32'h0);
        bus(0, REG_STATUS, 0);
        chk("inv_stat", q, 32'h0);
        bus(1, REG_PULSE_LEN, 32'h4);
        bus(1, REG_SELECT, 32'h3);
        bus(1, REG_LINE_CTRL, 32'h20);
        ev(3, 0);
        bus(1, REG_SELECT, 32'h5);
        bus(1, REG_LINE_CTRL, 32'h30);
        ev(5, 1);
        // Reset in mid-run with lines driven and registers changed
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1 chk("rst_lines", {14'h0, oe, pin, lvl}, 32'h0);
        chk("rst_wait", 32'(wreq), 32'h1);
        bus(0, REG_SETTLE, 0);
        chk("rst_settle", q, {16'h0, SETTLE_RST});
        bus(0, REG_SELECT, 0);
        chk("rst_sel", q, {29'h0, SELECT_RST});
        stop_test();
    end
endmodule

// ==== verilog/cil_line_ctrl.sv ====
// Module: per-line polarity, debounce, output source and Avalon-MM registers
//
// Behaviour
// - Report chosen line's logical level, read-only
// - Invert chosen line polarity, input or output
// - Accept input change after settle delay
// - Drive selection applies only to output lines
// - Sources: off, host level, event pulses
// - Host source follows software output level
// - Frame-begin source pulses at frame start
// - Row-begin source pulses at row start
// - Index selects one of six lines
// - Report each line's direction, read-only
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
module cil_line_ctrl
    import cil_pkg::*;
#(
    parameter int N_LINES = cil_pkg::NUM_LINES,
    parameter logic [N_LINES-1:0] DIR_OUTPUT = cil_pkg::DIR_OUTPUT_RST
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_frame_active,
    input wire logic i_row_active,
    input wire logic [N_LINES-1:0] i_line_pin,
    output logic [N_LINES-1:0] o_line_pin,
    output logic [N_LINES-1:0] o_line_pin_oe,
    output logic [N_LINES-1:0] o_line_input_level
);
    import cil_pkg::*;

    logic [SEL_W-1:0] line_index_select;
    logic [N_LINES-1:0] line_polarity_invert;
    logic [N_LINES-1:0] host_output_level;
    cil_src_t output_drive_select [N_LINES];
    logic [SETTLE_W-1:0] input_settle_delay;
    logic [PULSE_W-1:0] pulse_len;
    logic [N_LINES-1:0] line_level;
    cil_bus_t bus_state;
    logic frame_q;
    logic row_q;
    logic frame_start;
    logic row_start;
    logic [PULSE_W-1:0] frame_cnt;
    logic [PULSE_W-1:0] row_cnt;
    logic sel_ok;
    logic wr_take;

    assign sel_ok = (int'(line_index_select) < N_LINES);
    // A write lands only at the edge where the master sees waitrequest low
    assign wr_take = i_avs_write && (bus_state == CIL_BUS_DONE);
    assign frame_start = i_frame_active && !frame_q;
    assign row_start = i_row_active && !row_q;

    // Bus: one wait cycle per access, so every answer comes on the second edge
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            bus_state <= CIL_BUS_IDLE;
        end else begin
            unique case (bus_state)
                CIL_BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_state <= CIL_BUS_DONE;
                    end
                end
                CIL_BUS_DONE: begin
                    bus_state <= CIL_BUS_IDLE;
                end
                default: begin
                    bus_state <= CIL_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && bus_state == CIL_BUS_IDLE);
        end
    end

    // Register writes land at the edge that completes the transfer
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            line_index_select <= SELECT_RST;
            input_settle_delay <= SETTLE_RST;
            pulse_len <= PULSE_LEN_RST;
            line_polarity_invert <= '0;
            host_output_level <= '0;
            for (int k = 0; k < N_LINES; k++) begin
                output_drive_select[k] <= CIL_SRC_OFF;
            end
        end else if (wr_take) begin
            unique case (i_avs_address)
                REG_SELECT: begin
                    if (i_avs_byteenable[0]) begin
                        line_index_select <= i_avs_writedata[SEL_W-1:0];
                    end
                end
                REG_LINE_CTRL: begin
                    if (i_avs_byteenable[0] && sel_ok) begin
                        line_polarity_invert[line_index_select] <=
                            i_avs_writedata[CTRL_INVERT_BIT];
                        host_output_level[line_index_select] <=
                            i_avs_writedata[CTRL_LEVEL_BIT];
                        output_drive_select[line_index_select] <=
                            cil_src_t'(i_avs_writedata[CTRL_SRC_LSB +: CTRL_SRC_W]);
                    end
                end
                REG_SETTLE: begin
                    if (i_avs_byteenable[0]) begin
                        input_settle_delay[7:0] <= i_avs_writedata[7:0];
                    end
                    if (i_avs_byteenable[1]) begin
                        input_settle_delay[15:8] <= i_avs_writedata[15:8];
                    end
                end
                REG_PULSE_LEN: begin
                    if (i_avs_byteenable[0]) begin
                        pulse_len <= i_avs_writedata[PULSE_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && bus_state == CIL_BUS_IDLE) begin
            o_avs_readdata <= '0;
            unique case (i_avs_address)
                REG_SELECT: o_avs_readdata[SEL_W-1:0] <= line_index_select;
                REG_LINE_CTRL: begin
                    if (sel_ok) begin
                        o_avs_readdata[CTRL_INVERT_BIT] <= line_polarity_invert[line_index_select];
                        o_avs_readdata[CTRL_LEVEL_BIT] <= host_output_level[line_index_select];
                        o_avs_readdata[CTRL_SRC_LSB +: CTRL_SRC_W] <=
                            output_drive_select[line_index_select];
                    end
                end
                REG_SETTLE: o_avs_readdata[SETTLE_W-1:0] <= input_settle_delay;
                REG_STATUS: begin
                    if (sel_ok) begin
                        o_avs_readdata[STAT_LEVEL_BIT] <= line_level[line_index_select];
                        o_avs_readdata[STAT_DIR_BIT] <= DIR_OUTPUT[line_index_select];
                    end
                end
                REG_PULSE_LEN: o_avs_readdata[PULSE_W-1:0] <= pulse_len;
                default: o_avs_readdata <= '0;
            endcase
        end
    end

    // Event pulse stretchers shared by all lines on the same source
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            frame_q <= 1'b0;
            row_q <= 1'b0;
            frame_cnt <= '0;
            row_cnt <= '0;
        end else begin
            frame_q <= i_frame_active;
            row_q <= i_row_active;
            if (frame_start) begin
                frame_cnt <= pulse_len;
            end else if (frame_cnt != '0) begin
                frame_cnt <= frame_cnt - 1'b1;
            end
            if (row_start) begin
                row_cnt <= pulse_len;
            end else if (row_cnt != '0) begin
                row_cnt <= row_cnt - 1'b1;
            end
        end
    end

    for (genvar g = 0; g < N_LINES; g++) begin : g_line
        logic [SETTLE_W-1:0] settle_cnt;
        logic stable;
        logic next_drive;
        logic drive_en;

        if (DIR_OUTPUT[g]) begin : g_out
            always_comb begin
                next_drive = 1'b0;
                drive_en = 1'b1;
                unique case (output_drive_select[g])
                    CIL_SRC_OFF: drive_en = 1'b0;
                    CIL_SRC_HOST: next_drive = host_output_level[g];
                    CIL_SRC_FRAME: next_drive = (frame_cnt != '0);
                    CIL_SRC_ROW: next_drive = (row_cnt != '0);
                endcase
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    o_line_pin[g] <= 1'b0;
                    o_line_pin_oe[g] <= 1'b0;
                    line_level[g] <= 1'b0;
                end else begin
                    // Open line stays undriven, so inversion only matters when driven
                    o_line_pin[g] <= next_drive ^ line_polarity_invert[g];
                    o_line_pin_oe[g] <= drive_en;
                    line_level[g] <= next_drive;
                end
            end
            assign settle_cnt = '0;
            assign stable = 1'b0;
            always_ff @(posedge i_sys_clk) begin
                o_line_input_level[g] <= 1'b0;
            end
        end else begin : g_in
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    stable <= 1'b0;
                    settle_cnt <= '0;
                end else if (i_line_pin[g] == stable) begin
                    settle_cnt <= '0;
                end else if (settle_cnt + 1'b1 >= input_settle_delay) begin
                    stable <= i_line_pin[g];
                    settle_cnt <= '0;
                end else begin
                    settle_cnt <= settle_cnt + 1'b1;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    line_level[g] <= 1'b0;
                    o_line_input_level[g] <= 1'b0;
                end else begin
                    line_level[g] <= stable ^ line_polarity_invert[g];
                    o_line_input_level[g] <= stable ^ line_polarity_invert[g];
                end
            end
            assign next_drive = 1'b0;
            assign drive_en = 1'b0;
            always_ff @(posedge i_sys_clk) begin
                o_line_pin[g] <= 1'b0;
                o_line_pin_oe[g] <= 1'b0;
            end
        end
    end
endmodule

// ==== verilog/cil_pkg.sv ====
// Package: constants and types for the camera I/O line control block
package cil_pkg;
    localparam int NUM_LINES = 6;
    localparam int SEL_W = 3;
    localparam int SETTLE_W = 16;
    localparam int PULSE_W = 8;

    // Register byte offsets (Avalon-MM word addresses times four)
    localparam logic [7:0] REG_SELECT = 8'h00;
    localparam logic [7:0] REG_LINE_CTRL = 8'h04;
    localparam logic [7:0] REG_SETTLE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PULSE_LEN = 8'h10;

    // Line control field positions
    localparam int CTRL_INVERT_BIT = 0;
    localparam int CTRL_LEVEL_BIT = 1;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_SRC_W = 2;

    // Status field positions
    localparam int STAT_LEVEL_BIT = 0;
    localparam int STAT_DIR_BIT = 1;

    // Reset values
    localparam logic [SEL_W-1:0] SELECT_RST = 3'h0;
    localparam logic [SETTLE_W-1:0] SETTLE_RST = 16'h0064;
    localparam logic [PULSE_W-1:0] PULSE_LEN_RST = 8'h0a;
    localparam logic [NUM_LINES-1:0] DIR_OUTPUT_RST = 6'h2a;

    typedef enum logic [1:0] {
        CIL_SRC_OFF = 2'h0,
        CIL_SRC_HOST = 2'h1,
        CIL_SRC_FRAME = 2'h2,
        CIL_SRC_ROW = 2'h3
    } cil_src_t;

    typedef enum logic [1:0] {
        CIL_BUS_IDLE = 2'h1,
        CIL_BUS_DONE = 2'h2
    } cil_bus_t;
endpackage
